// file: icw_pkg.sv
// Purpose: shared constants for the two-wire config register write link
// Assumes: 50 MHz system clock, link bit period set by the controller divider
// Notes: both ends and the controller register map use these names
package icw_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned LINK_PERIOD_NS = 160;
   // four phases per link bit
   localparam int unsigned QTR_CYC        = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // slave address: upper four bits fixed, low three from straps
   localparam logic [3:0]  SLV_ADDR_HI    = 4'hD;
   localparam logic [6:0]  SLV_ADDR_DFLT  = 7'h68;
   localparam logic [2:0]  OP_WRITE       = 3'h3;
   localparam logic [4:0]  PORT_MAX       = 5'h05;
   localparam int unsigned NUM_PORTS      = 6;
   localparam int unsigned NUM_LANES      = 4;
   // byte index within a transfer: 0 address, 1..4 command, 5..8 data
   localparam logic [3:0]  FIRST_CMD      = 4'h1;
   localparam logic [3:0]  LAST_CMD       = 4'h4;
   localparam logic [3:0]  LAST_DATA      = 4'h8;
   localparam logic [3:0]  BYTE_CAP       = 4'h9;
   localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
   // controller registers
   localparam int unsigned AXI_AW         = 4;
   localparam logic [3:0]  REG_CTRL       = 4'h0;
   localparam logic [3:0]  REG_CMD        = 4'h4;
   localparam logic [3:0]  REG_DATA       = 4'h8;
   localparam int unsigned CTRL_GO        = 0;
   localparam int unsigned STAT_BUSY      = 0;
   localparam int unsigned STAT_NACK      = 1;
   localparam int unsigned CMD_DADDR_LSB  = 0;
   localparam int unsigned CMD_BE_LSB     = 12;
   localparam int unsigned CMD_PORT_LSB   = 16;
   localparam int unsigned CMD_SADDR_LSB  = 24;
   localparam logic [31:0] CMD_RST        = 32'h6800_0000;
   localparam logic [31:0] DATA_RST       = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   typedef enum logic [3:0] {
      DS_IDLE = 4'b0001,
      DS_BITS = 4'b0010,
      DS_ACK  = 4'b0100,
      DS_SKIP = 4'b1000
   } icw_dev_state_e;
   typedef enum logic [4:0] {
      MS_IDLE  = 5'b00001,
      MS_START = 5'b00010,
      MS_BIT   = 5'b00100,
      MS_ACK   = 5'b01000,
      MS_STOP  = 5'b10000
   } icw_ctl_state_e;
endpackage : icw_pkg

// file: icw_if.sv
// Purpose: open-drain two-wire link between controller and device
// Assumes: pull-ups on both wires, modelled by the wired-and below
// Notes: an enable high pulls the wire to its output value
`timescale 1ns/1ps
interface icw_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;
   assign scl = !(scl_oe && !scl_o);
   assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);
   modport ctl (output scl_o, scl_oe, m_sda_o, m_sda_oe, input scl, sda);
   modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface : icw_if

// file: icw_ctl.sv
// Purpose: link controller that sends one register write per software order
// Assumes: AXI4-Lite register access, link wires sampled on clk_sys
// Notes: no clock stretching; a not-acknowledge ends the transfer early
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module icw_ctl (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      reset_n,
   input  wire logic                      ce,
   // register bus
   input  wire logic                      s_axi_awvalid,
   output wire logic                      s_axi_awready,
   input  wire logic [icw_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_wvalid,
   output wire logic                      s_axi_wready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   output logic [1:0]                     s_axi_bresp,
   input  wire logic                      s_axi_arvalid,
   output wire logic                      s_axi_arready,
   input  wire logic [icw_pkg::AXI_AW-1:0] s_axi_araddr,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   // link
   icw_if.ctl                             link
);
   import icw_pkg::*;

   logic [31:0]    cmd_reg;
   logic [31:0]    data_reg;
   logic           busy;
   logic           nack_flag;
   logic [1:0]     sda_sy;
   icw_ctl_state_e state;
   logic [1:0]     qcnt;
   logic [1:0]     ph;
   logic [2:0]     bit_cnt;
   logic [3:0]     byte_idx;
   logic [7:0]     shreg;
   logic           scl_oe;
   logic           sda_oe;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < NUM_LANES; i++)
      begin
         if (s[i])
            r[8*i +: 8] = n[8*i +: 8];
      end
      return r;
   endfunction : merge

   function automatic logic known(input logic [AXI_AW-1:0] a);
      return (a == REG_CTRL) || (a == REG_CMD) || (a == REG_DATA);
   endfunction : known

   // bytes in wire order
   function automatic logic [7:0] byte_of(input logic [3:0] i, input logic [31:0] c, input logic [31:0] d);
      logic [4:0] p;
      logic [9:0] a;
      p = c[CMD_PORT_LSB +: 5];
      a = c[CMD_DADDR_LSB +: 10];
      case (i)
         4'h0: byte_of = {c[CMD_SADDR_LSB +: 7], 1'b0};
         4'h1: byte_of = {5'h00, OP_WRITE};
         4'h2: byte_of = {4'h0, p[4:1]};
         4'h3: byte_of = {p[0], 1'b0, c[CMD_BE_LSB +: 4], a[9:8]};
         4'h4: byte_of = a[7:0];
         4'h5: byte_of = d[31:24];
         4'h6: byte_of = d[23:16];
         4'h7: byte_of = d[15:8];
         4'h8: byte_of = d[7:0];
         default: byte_of = 8'hFF;
      endcase
   endfunction : byte_of

   // waiting for both halves keeps one write decode and one response path
   wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_take = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_arready = ~s_axi_rvalid;
   wire go = wr_take & (s_axi_awaddr == REG_CTRL) & s_axi_wstrb[0] & s_axi_wdata[CTRL_GO] & ~busy;
   wire tick     = (qcnt == 2'(QTR_CYC - 1));
   wire step_end = tick & (ph == 2'h3);
   wire sda_in   = sda_sy[1];
   wire next_scl_oe = ((state == MS_START) & ph[1]) | ((state == MS_BIT) & ~ph[1])
                    | ((state == MS_ACK) & ~ph[1]) | ((state == MS_STOP) & ~ph[1]);
   wire next_sda_oe = ((state == MS_START) & (ph != 2'h0)) | ((state == MS_BIT) & ~shreg[7])
                    | ((state == MS_STOP) & (ph != 2'h3));
   assign link.scl_o   = 1'b0;
   assign link.m_sda_o = 1'b0;
   assign link.scl_oe  = scl_oe;
   assign link.m_sda_oe = sda_oe;
   wire [31:0] rd_word = (s_axi_araddr == REG_CTRL) ? {30'h0, nack_flag, busy} :
                         (s_axi_araddr == REG_CMD) ? cmd_reg :
                         (s_axi_araddr == REG_DATA) ? data_reg : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
         cmd_reg      <= CMD_RST;
         data_reg     <= DATA_RST;
      end
      else if (ce)
      begin
         if (wr_take)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_awaddr == REG_CMD)
               cmd_reg <= merge(cmd_reg, s_axi_wdata, s_axi_wstrb);
            if (s_axi_awaddr == REG_DATA)
               data_reg <= merge(data_reg, s_axi_wdata, s_axi_wstrb);
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sda_sy <= 2'b11;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (ce)
      begin
         sda_sy <= {sda_sy[0], link.sda};
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
      end
   end

   // start, address, four command bytes, four data bytes, stop
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state     <= MS_IDLE;
         busy      <= 1'b0;
         nack_flag <= 1'b0;
         qcnt      <= 2'h0;
         ph        <= 2'h0;
         bit_cnt   <= 3'h0;
         byte_idx  <= 4'h0;
         shreg     <= 8'hFF;
      end
      else if (ce)
      begin
         if (state == MS_IDLE)
         begin
            qcnt <= 2'h0;
            ph   <= 2'h0;
            if (go)
            begin
               state     <= MS_START;
               busy      <= 1'b1;
               nack_flag <= 1'b0;
               byte_idx  <= 4'h0;
               shreg     <= byte_of(4'h0, cmd_reg, data_reg);
            end
         end
         else
         begin
            qcnt <= tick ? 2'h0 : qcnt + 2'h1;
            if (tick)
               ph <= ph + 2'h1;
            if (step_end)
            begin
               case (state)
                  MS_START:
                  begin
                     state   <= MS_BIT;
                     bit_cnt <= 3'h0;
                  end
                  MS_BIT:
                  begin
                     shreg   <= {shreg[6:0], 1'b1};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7)
                        state <= MS_ACK;
                  end
                  MS_ACK:
                  begin
                     if (sda_in || (byte_idx == LAST_DATA))
                     begin
                        state     <= MS_STOP;
                        nack_flag <= nack_flag | sda_in;
                     end
                     else
                     begin
                        state    <= MS_BIT;
                        bit_cnt  <= 3'h0;
                        byte_idx <= byte_idx + 4'h1;
                        shreg    <= byte_of(byte_idx + 4'h1, cmd_reg, data_reg);
                     end
                  end
                  MS_STOP:
                  begin
                     state <= MS_IDLE;
                     busy  <= 1'b0;
                  end
                  default:
                     state <= MS_IDLE;
               endcase
            end
         end
      end
   end
endmodule : icw_ctl

// file: icw_dev.sv
// Purpose: device end of the two-wire link, turns write packets into register writes
// Assumes: link wires and straps are asynchronous to clk_sys and pass two flops
// Notes: only the write packet is decoded; read requests get a not-acknowledge
`timescale 1ns/1ps
module icw_dev (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           reset_n,
   input  wire logic                           ce,
   // address straps
   input  wire logic [2:0]                     strap,
   // link
   icw_if.dev                                  link,
   // register write port
   output logic                                wr_strobe,
   output logic [4:0]                          wr_port,
   output logic [icw_pkg::NUM_PORTS-1:0]       wr_port_sel,
   output logic [icw_pkg::NUM_LANES-1:0]       wr_be,
   output logic [31:0]                         wr_mask,
   output logic [11:0]                         wr_addr,
   output logic [31:0]                         wr_data
);
   import icw_pkg::*;

   // [0] first flop, [1] second flop, [2] history for edge finding
   logic [2:0]     scl_sy;
   logic [2:0]     sda_sy;
   logic [2:0]     strap_s1;
   logic [2:0]     strap_s2;
   icw_dev_state_e state;
   logic [7:0]     shreg;
   logic [3:0]     bit_cnt;
   logic [3:0]     byte_cnt;
   logic [7:0]     cmd [0:3];
   logic [31:0]    dat;
   logic           ack_drv;

   wire scl_rise  = scl_sy[1] & ~scl_sy[2];
   wire scl_fall  = ~scl_sy[1] & scl_sy[2];
   // data moving while the clock stays high marks frame edges
   wire start_det = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
   wire stop_det  = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];

   wire [2:0]  opcode = cmd[0][2:0];
   wire [4:0]  port   = {cmd[1][3:0], cmd[2][7]};
   wire [3:0]  lanes  = cmd[2][5:2];
   wire [9:0]  daddr  = {cmd[2][1:0], cmd[3]};
   wire [3:0]  cmd_idx = byte_cnt - FIRST_CMD;
   wire        is_cmd  = (byte_cnt >= FIRST_CMD) && (byte_cnt <= LAST_CMD);
   wire        is_data = (byte_cnt > LAST_CMD) && (byte_cnt <= LAST_DATA);
   wire        addr_hit = (shreg[7:1] == {SLV_ADDR_HI, strap_s2}) && !shreg[0];
   // address byte needs a match; beyond the fourth data byte nothing is taken
   wire        byte_ack = (byte_cnt == 4'h0) ? addr_hit : (byte_cnt <= LAST_DATA);
   wire        cmd_ok   = (opcode == OP_WRITE) && (port <= PORT_MAX);
   wire        commit   = (state == DS_ACK) && scl_fall && ack_drv && (byte_cnt == LAST_DATA);
   wire [NUM_PORTS-1:0] port_dec;
   wire [31:0]          lane_mask;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_port
         assign port_dec[gi] = (port == 5'(gi));
      end
      for (gi = 0; gi < NUM_LANES; gi++)
      begin : g_lane
         assign lane_mask[8*gi +: 8] = {8{lanes[gi]}};
      end
   endgenerate

   assign link.d_sda_o  = 1'b0;
   assign link.d_sda_oe = ack_drv;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scl_sy   <= 3'b111;
         sda_sy   <= 3'b111;
         strap_s1 <= 3'b000;
         strap_s2 <= 3'b000;
      end
      else if (ce)
      begin
         scl_sy   <= {scl_sy[1:0], link.scl};
         sda_sy   <= {sda_sy[1:0], link.sda};
         strap_s1 <= strap;
         strap_s2 <= strap_s1;
      end
   end

   // byte receiver and acknowledge driver
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state    <= DS_IDLE;
         shreg    <= 8'h00;
         bit_cnt  <= 4'h0;
         byte_cnt <= 4'h0;
         dat      <= 32'h0000_0000;
         ack_drv  <= 1'b0;
         for (int i = 0; i < 4; i++)
            cmd[i] <= 8'h00;
      end
      else if (ce)
      begin
         if (start_det)
         begin
            // a repeated start also lands here and begins a fresh packet
            state    <= DS_BITS;
            bit_cnt  <= 4'h0;
            byte_cnt <= 4'h0;
            ack_drv  <= 1'b0;
         end
         else if (stop_det)
         begin
            state   <= DS_IDLE;
            ack_drv <= 1'b0;
         end
         else
         begin
            case (state)
               DS_BITS:
               begin
                  if (scl_rise)
                  begin
                     shreg   <= {shreg[6:0], sda_sy[1]};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && (bit_cnt == BITS_PER_BYTE))
                  begin
                     state   <= DS_ACK;
                     bit_cnt <= 4'h0;
                     ack_drv <= byte_ack;
                     if (is_cmd)
                        cmd[cmd_idx[1:0]] <= shreg;
                     if (is_data)
                        dat <= {dat[23:0], shreg};
                  end
               end
               DS_ACK:
               begin
                  if (scl_fall)
                  begin
                     ack_drv <= 1'b0;
                     // an unmatched address sits out the rest of the frame
                     state   <= ((byte_cnt == 4'h0) && !ack_drv) ? DS_SKIP : DS_BITS;
                     if (byte_cnt != BYTE_CAP)
                        byte_cnt <= byte_cnt + 4'h1;
                  end
               end
               DS_IDLE, DS_SKIP:
                  ack_drv <= 1'b0;
               default:
                  state <= DS_IDLE;
            endcase
         end
      end
   end

   // register write port, one pulse per accepted packet
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_strobe   <= 1'b0;
         wr_port     <= 5'h00;
         wr_port_sel <= '0;
         wr_be       <= 4'h0;
         wr_mask     <= 32'h0000_0000;
         wr_addr     <= 12'h000;
         wr_data     <= 32'h0000_0000;
      end
      else if (ce)
      begin
         wr_strobe <= commit && cmd_ok;
         if (commit && cmd_ok)
         begin
            wr_port     <= port;
            wr_port_sel <= port_dec;
            wr_be       <= lanes;
            wr_mask     <= lane_mask;
            wr_addr     <= {daddr, 2'b00};
            wr_data     <= dat;
         end
      end
   end
endmodule : icw_dev

// file: icw_link_assertions.sv
// Purpose: link checks for the two-wire write link
// Assumes: one clk_sys domain, wires sampled as the controller drives them
// Notes: bit and byte counts rebuilt here from scl and sda
`timescale 1ns/1ps
module icw_link_assertions (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // link
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       m_sda_oe,
   input wire logic       d_sda_oe,
   // device side
   input wire logic [2:0] strap,
   input wire logic       wr_strobe
);
   import icw_pkg::*;
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bit_cnt;
   logic [3:0] byte_cnt;
   logic [8:0] shift;
   wire        start_seen = scl && scl_q && sda_q && !sda;
   wire        rise       = scl && !scl_q;
   wire        ack_slot   = scl && scl_q && (bit_cnt == 4'h9);
   wire [7:0]  addr_exp   = {SLV_ADDR_HI, strap, 1'b0};
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         bit_cnt  <= 4'h0;
         byte_cnt <= 4'h0;
         shift    <= 9'h000;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_seen)
         begin
            bit_cnt  <= 4'h0;
            byte_cnt <= 4'h0;
         end
         else if (rise)
         begin
            bit_cnt  <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
            byte_cnt <= (bit_cnt == 4'h8) ? byte_cnt + 4'h1 : byte_cnt;
            shift    <= {shift[7:0], sda};
         end
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_start;
      scl && $fell(sda);
   endsequence
   // start may stretch the first low phase, hence the wider bound
   sequence s_low_phase;
      (!scl)[*3] ##[1:8] scl;
   endsequence
   chk_start_frame: assert property (s_start |-> ##[1:8] !scl)
      else $error("scl not pulled after start");
   chk_scl_low: assert property ($fell(scl) |-> s_low_phase)
      else $error("scl low phase wrong length");
   chk_scl_high: assert property ($rose(scl) |-> scl[*4])
      else $error("scl high phase too short");
   chk_addr_ack: assert property (ack_slot && byte_cnt == 4'h1 |-> d_sda_oe == (shift[8:1] == addr_exp))
      else $error("address byte answered wrongly");
   chk_opcode_sent: assert property (ack_slot && byte_cnt == 4'h2 |-> shift[3:1] == OP_WRITE)
      else $error("first command byte lacks write code");
   chk_ack_only_slot: assert property (d_sda_oe && scl && scl_q |-> bit_cnt == 4'h9)
      else $error("device drives sda outside ack slot");
   chk_ack_held: assert property ($rose(d_sda_oe) |-> d_sda_oe[*6])
      else $error("device ack not held");
   chk_ctl_release: assert property (ack_slot |-> !m_sda_oe)
      else $error("controller drives sda in ack slot");
   chk_commit_after: assert property (wr_strobe |-> byte_cnt == 4'h9)
      else $error("register write before fourth data byte");
   chk_write_bit: assert property (ack_slot && byte_cnt == 4'h1 |-> !shift[1])
      else $error("address byte not marked as a write");
   chk_data_count: assert property (byte_cnt <= 4'h9)
      else $error("more than four data bytes sent");
endmodule : icw_link_assertions

// file: testbench.sv
// Purpose: self-checking bench, controller and device joined by the link
// Assumes: 50 MHz clk_sys, registers reached over AXI4-Lite
// Notes: ordinary packets are table rows; a single mid-frame reset case follows the loop
`timescale 1ns/1ps
module testbench;
   import icw_pkg::*;
   typedef struct packed {logic [2:0] strap; logic [6:0] sa; logic [4:0] port; logic [3:0] be;
      logic [9:0] dw; logic [31:0] data; logic ok; logic nack;} icw_row_s;
   logic                 clk_sys = 1'b0;
   logic                 reset_n = 1'b0;
   logic [2:0]           strap = 3'h0;
   logic                 awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [3:0]           awa = 4'h0, ara = 4'h0, ws = 4'hF;
   logic [31:0]          wd = 32'h0, rdata, rd, wr_mask, wr_data;
   logic [1:0]           bresp, rresp, rs;
   wire                  awr, wrr, bv, arr, rv;
   logic                 wr_strobe;
   logic [4:0]           wr_port;
   logic [NUM_PORTS-1:0] wr_port_sel;
   logic [3:0]           wr_be;
   logic [11:0]          wr_addr;
   int                   n_mismatch = 0, samples_checked = 0, n_strobe = 0, cyc = 0;
   // rows: strap, slave address, port, lanes, dword address, data, written, refused
   icw_row_s rows [6] = '{
      '{3'h0, 7'h68, 5'h00, 4'hF, 10'h03E, 32'h1234_5678, 1'b1, 1'b0},
      '{3'h0, 7'h68, 5'h05, 4'h1, 10'h3FF, 32'hA5A5_A5A5, 1'b1, 1'b0},
      '{3'h0, 7'h68, 5'h03, 4'hA, 10'h200, 32'hDEAD_BEEF, 1'b1, 1'b0},
      '{3'h5, 7'h6D, 5'h01, 4'h0, 10'h001, 32'h0F0F_0F0F, 1'b1, 1'b0},
      '{3'h5, 7'h68, 5'h00, 4'hF, 10'h000, 32'h0000_0001, 1'b0, 1'b1},
      '{3'h0, 7'h68, 5'h06, 4'hF, 10'h000, 32'h0000_0001, 1'b0, 1'b0}};
   icw_if icw_if_i ();
   icw_ctl icw_ctl_i (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .link(icw_if_i));
   icw_dev icw_dev_i (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .strap(strap), .link(icw_if_i),
      .wr_strobe(wr_strobe), .wr_port(wr_port), .wr_port_sel(wr_port_sel), .wr_be(wr_be), .wr_mask(wr_mask),
      .wr_addr(wr_addr), .wr_data(wr_data));
   icw_link_assertions icw_link_assertions_i (.clk_sys(clk_sys), .reset_n(reset_n), .scl(icw_if_i.scl),
      .sda(icw_if_i.sda), .m_sda_oe(icw_if_i.m_sda_oe), .d_sda_oe(icw_if_i.d_sda_oe), .strap(strap),
      .wr_strobe(wr_strobe));
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (wr_strobe === 1'b1)
         n_strobe++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // no cycle count assumed: only the bench timeout ends a wait
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      do @(posedge clk_sys); while (!(awr && wrr));
      awv <= 1'b0;
      wv  <= 1'b0;
      bry <= 1'b1;
      do @(posedge clk_sys); while (!bv);
      r = bresp;
      bry <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk_sys); while (!arr);
      arv <= 1'b0;
      rry <= 1'b1;
      do @(posedge clk_sys); while (!rv);
      d = rdata;
      r = rresp;
      rry <= 1'b0;
   endtask : axi_rd
   task automatic do_row(input icw_row_s w);
      int n0;
      strap <= w.strap;
      repeat (3) @(posedge clk_sys);
      n0 = n_strobe;
      axi_wr(REG_DATA, w.data, rs);
      axi_wr(REG_CMD, {1'b0, w.sa, 3'h0, w.port, w.be, 2'h0, w.dw}, rs);
      axi_wr(REG_CTRL, 32'h1, rs);
      do axi_rd(REG_CTRL, rd, rs); while (rd[STAT_BUSY] === 1'b1);
      chk(32'(n_strobe - n0), {31'h0, w.ok});
      chk({31'h0, rd[STAT_NACK]}, {31'h0, w.nack});
      if (w.ok)
      begin
         chk(wr_data, w.data);
         chk(wr_mask, {{8{w.be[3]}}, {8{w.be[2]}}, {8{w.be[1]}}, {8{w.be[0]}}});
         chk({28'h0, wr_be}, {28'h0, w.be});
         chk({20'h0, wr_addr}, {20'h0, w.dw, 2'h0});
         chk({27'h0, wr_port}, {27'h0, w.port});
         chk({26'h0, wr_port_sel}, 32'h1 << w.port);
      end
   endtask : do_row
   initial
   begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      axi_rd(REG_CMD, rd, rs);
      chk(rd, CMD_RST);
      axi_rd(REG_DATA, rd, rs);
      chk(rd, DATA_RST);
      axi_rd(4'hC, rd, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_wr(4'hC, 32'hFFFF_FFFF, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      // lane strobes: only byte 0 of data lands, and go without lane 0 is ignored
      ws <= 4'h1;
      axi_wr(REG_DATA, 32'hFFFF_FFFF, rs);
      ws <= 4'hE;
      axi_wr(REG_CTRL, 32'h1, rs);
      ws <= 4'hF;
      axi_rd(REG_DATA, rd, rs);
      chk(rd, 32'h0000_00FF);
      axi_rd(REG_CTRL, rd, rs);
      chk(rd, 32'h0000_0000);
      foreach (rows[i])
         do_row(rows[i]);
      // reset in mid-frame must free both wires and clear wr_data on the write port
      axi_wr(REG_CTRL, 32'h1, rs);
      repeat (300) @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({30'h0, icw_if_i.scl, icw_if_i.sda}, 32'h3);
      chk(wr_data, 32'h0);
      reset_n <= 1'b1;
      do_row(rows[0]);
      end_of_test();
   end
endmodule : testbench
